/* File: design/tss_pkg.sv */
package tss_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_SLAVE = 8'h08;
  localparam logic [7:0] OFS_IEN = 8'h0c;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_EVGEN = 8'h14;
  localparam logic [7:0] OFS_CHAN = 8'h18;
  localparam logic [7:0] OFS_RELOAD = 8'h2c;
  localparam logic [7:0] OFS_CMP0 = 8'h34;
  localparam logic [7:0] OFS_CNT = 8'h24;

  // ==========================================================================
  // Field positions
  localparam int CTL_RUN = 0;
  localparam int CTL_UPSUP = 1;
  localparam int CTL_UPSRC = 2;
  localparam int CTL_ONESHOT = 3;
  localparam int CTL_SHADOW = 7;
  localparam int CTL_DIV_LO = 8;
  localparam int SMC_LO = 0;
  localparam int TRG_LO = 4;
  localparam int SMC_SYNC = 7;
  localparam int IEN_UP = 0;
  localparam int IEN_CH0 = 1;
  localparam int IEN_CH1 = 2;
  localparam int IEN_TRG = 6;
  localparam int FLG_UP = 0;
  localparam int FLG_TRG = 6;
  localparam int EVG_UP = 0;
  localparam int EVG_TRG = 6;
  localparam int CH0_FAST = 2;
  localparam int CH0_MODE_LO = 4;
  localparam int CH0_FILT_LO = 4;
  localparam int CH1_FILT_LO = 12;
  localparam int CH0_POL = 0;
  localparam int CH1_POL = 1;

  // ==========================================================================
  // Masks and reset values
  localparam logic [31:0] CTRL0_MASK = 32'h0000_038f;
  localparam logic [31:0] SLAVE_MASK = 32'h0000_00f7;
  localparam logic [31:0] IEN_MASK = 32'h0000_0047;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [15:0] RELOAD_RST = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  // ==========================================================================
  // Codes
  localparam logic [2:0] SM_OFF = 3'b000;
  localparam logic [2:0] SM_RESTART = 3'b100;
  localparam logic [2:0] SM_PAUSE = 3'b101;
  localparam logic [2:0] SM_EVENT = 3'b110;
  localparam logic [2:0] SM_EXTCLK = 3'b111;
  localparam logic [2:0] TS_EDGE0 = 3'b100;
  localparam logic [2:0] TS_FILT0 = 3'b101;
  localparam logic [2:0] TS_FILT1 = 3'b110;
  localparam logic [2:0] CMP_PWM0 = 3'b110;
  localparam logic [2:0] CMP_PWM1 = 3'b111;
  localparam logic [1:0] DIV_1 = 2'b00;
  localparam logic [1:0] DIV_2 = 2'b01;
  localparam logic [1:0] DIV_4 = 2'b10;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef enum logic [1:0] {TSS_IDLE, TSS_WRITE, TSS_READ} tss_phase_e;

  typedef struct packed {
    logic [3:0] itrig;
    logic ch0;
    logic ch1;
  } tss_trig_in_s;

  typedef struct packed {
    tss_phase_e phase;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic [31:0] ctrl0;
    logic [31:0] slave;
    logic [31:0] ien;
    logic upd_flag;
    logic trg_flag;
    logic [15:0] chan;
    logic [3:0] chpol;
    logic [15:0] reload_pre;
    logic [15:0] reload;
    logic [15:0] cmp0;
    logic [15:0] cnt;
    logic [3:0] itr_s1;
    logic [3:0] itr_s2;
    logic [1:0] ch_s1;
    logic [1:0] ch_s2;
    logic [1:0] div_cnt;
    logic [3:0] f0_cnt;
    logic [3:0] f1_cnt;
    logic f0;
    logic f1;
    logic trig_prev;
    logic oprep;
    logic upd_pulse;
    logic trg_out;
  } tss_state_s;

endpackage : tss_pkg

/* File: design/tss_timer_slave.sv */
`timescale 1ns/1ns
`default_nettype none
module tss_timer_slave
  import tss_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire tss_trig_in_s trig_in,
  output logic trigger_output,
  output logic output_prepare_level,
  output logic update_event,
  output logic [15:0] counter_value
);

  // ==========================================================================
  // Helpers
  function automatic logic [3:0] filt_len(input logic [3:0] code);
    filt_len = (code == 4'h0) ? 4'h0 : {code[2:0], 1'b0};
  endfunction : filt_len

  tss_state_s st_ff;
  tss_state_s nxt_st;

  logic [2:0] smode;
  logic [2:0] tsel;
  logic sample_tick;
  logic trig_lvl;
  logic trig_rise;
  logic trig_fall;
  logic trig_evt;
  logic count_en;
  logic overflow;
  logic sw_upd;
  logic restart;
  logic upd_ok;
  logic upd_flag_set;
  logic pwm_mode;

  always_comb begin
    smode = st_ff.slave[SMC_LO +: 3];
    tsel = st_ff.slave[TRG_LO +: 3];
    if (smode inside {3'b001, 3'b010, 3'b011}) begin
      smode = SM_OFF;
    end
    case (st_ff.ctrl0[CTL_DIV_LO +: 2])
      DIV_1: sample_tick = 1'b1;
      DIV_2: sample_tick = st_ff.div_cnt[0];
      DIV_4: sample_tick = &st_ff.div_cnt;
      default: sample_tick = 1'b1;
    endcase
    // Internal triggers skip the filter; channels use filtered copies
    case (tsel)
      3'b000, 3'b001, 3'b010, 3'b011: trig_lvl = st_ff.itr_s2[tsel[1:0]];
      TS_EDGE0: trig_lvl = st_ff.f0;
      TS_FILT0: trig_lvl = st_ff.f0 ^ st_ff.chpol[CH0_POL];
      TS_FILT1: trig_lvl = st_ff.f1 ^ st_ff.chpol[CH1_POL];
      default: trig_lvl = 1'b0;
    endcase
    trig_rise = trig_lvl & ~st_ff.trig_prev;
    trig_fall = ~trig_lvl & st_ff.trig_prev;
    if (tsel == TS_EDGE0) begin
      trig_rise = trig_rise | trig_fall;
      trig_fall = 1'b0;
    end
    trig_evt = (smode == SM_PAUSE) ? (trig_rise | trig_fall) : trig_rise;
    case (smode)
      SM_PAUSE: count_en = st_ff.ctrl0[CTL_RUN] & trig_lvl;
      SM_EXTCLK: count_en = st_ff.ctrl0[CTL_RUN] & trig_rise;
      default: count_en = st_ff.ctrl0[CTL_RUN];
    endcase
    overflow = count_en && (st_ff.cnt >= st_ff.reload);
    pwm_mode = st_ff.chan[CH0_MODE_LO +: 3] inside {CMP_PWM0, CMP_PWM1};
  end

  // ==========================================================================
  // Bus, registers and counter
  always_comb begin
    nxt_st = st_ff;
    sw_upd = 1'b0;
    nxt_st.upd_pulse = 1'b0;
    nxt_st.trg_out = 1'b0;
    nxt_st.itr_s1 = trig_in.itrig;
    nxt_st.itr_s2 = st_ff.itr_s1;
    nxt_st.ch_s1 = {trig_in.ch1, trig_in.ch0};
    nxt_st.ch_s2 = st_ff.ch_s1;
    nxt_st.div_cnt = st_ff.div_cnt + 2'd1;
    nxt_st.trig_prev = trig_lvl;
    if (sample_tick) begin
      if (st_ff.ch_s2[0] == st_ff.f0 || st_ff.f0_cnt >= filt_len(st_ff.chan[CH0_FILT_LO +: 4])) begin
        nxt_st.f0 = st_ff.ch_s2[0];
        nxt_st.f0_cnt = 4'h0;
      end else begin
        nxt_st.f0_cnt = st_ff.f0_cnt + 4'h1;
      end
      if (st_ff.ch_s2[1] == st_ff.f1 || st_ff.f1_cnt >= filt_len(st_ff.chan[CH1_FILT_LO +: 4])) begin
        nxt_st.f1 = st_ff.ch_s2[1];
        nxt_st.f1_cnt = 4'h0;
      end else begin
        nxt_st.f1_cnt = st_ff.f1_cnt + 4'h1;
      end
    end
    // Data phase of a previous address phase
    case (st_ff.phase)
      TSS_WRITE: begin
        case (st_ff.addr)
          OFS_CTRL0: nxt_st.ctrl0 = hwdata & CTRL0_MASK;
          OFS_SLAVE: nxt_st.slave = hwdata & SLAVE_MASK;
          OFS_IEN: nxt_st.ien = hwdata & IEN_MASK;
          OFS_FLAGS: begin
            nxt_st.upd_flag = st_ff.upd_flag & hwdata[FLG_UP];
            nxt_st.trg_flag = st_ff.trg_flag & hwdata[FLG_TRG];
          end
          OFS_EVGEN: begin
            sw_upd = hwdata[EVG_UP];
            if (hwdata[EVG_TRG]) begin
              nxt_st.trg_flag = 1'b1;
            end
          end
          OFS_CHAN: nxt_st.chan = hwdata[15:0];
          OFS_RELOAD: begin
            nxt_st.reload_pre = hwdata[15:0];
            if (!st_ff.ctrl0[CTL_SHADOW]) begin
              nxt_st.reload = hwdata[15:0];
            end
          end
          OFS_CMP0: nxt_st.cmp0 = hwdata[15:0];
          default: nxt_st.chpol = hwdata[3:0];
        endcase
      end
      default: ;
    endcase
    nxt_st.phase = TSS_IDLE;
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      nxt_st.addr = haddr[7:0];
      nxt_st.phase = hwrite ? TSS_WRITE : TSS_READ;
      case (haddr[7:0])
        OFS_CTRL0: nxt_st.rdata = st_ff.ctrl0;
        OFS_SLAVE: nxt_st.rdata = st_ff.slave;
        OFS_IEN: nxt_st.rdata = st_ff.ien;
        OFS_FLAGS: nxt_st.rdata = {25'h0, st_ff.trg_flag, 5'h0, st_ff.upd_flag};
        OFS_CHAN: nxt_st.rdata = {16'h0, st_ff.chan};
        OFS_RELOAD: nxt_st.rdata = {16'h0, st_ff.reload_pre};
        OFS_CMP0: nxt_st.rdata = {16'h0, st_ff.cmp0};
        OFS_CNT: nxt_st.rdata = {16'h0, st_ff.cnt};
        default: nxt_st.rdata = RESET_WORD;
      endcase
    end
    // Start conditions
    if (trig_rise && (smode == SM_EVENT || st_ff.ctrl0[CTL_ONESHOT])) begin
      nxt_st.ctrl0[CTL_RUN] = 1'b1;
    end
    if (trig_rise && st_ff.slave[SMC_SYNC]) begin
      nxt_st.trg_out = 1'b1;
    end
    if (trig_evt) begin
      nxt_st.trg_flag = 1'b1;
    end
    restart = (smode == SM_RESTART) && trig_rise;
    upd_ok = !st_ff.ctrl0[CTL_UPSUP] && (overflow || sw_upd || restart);
    upd_flag_set = upd_ok && (overflow || !st_ff.ctrl0[CTL_UPSRC]);
    if (upd_flag_set) begin
      nxt_st.upd_flag = 1'b1;
    end
    if (sw_upd || restart || overflow) begin
      nxt_st.cnt = CNT_ZERO;
    end else if (count_en) begin
      nxt_st.cnt = st_ff.cnt + 16'h0001;
    end
    if (upd_ok) begin
      nxt_st.upd_pulse = 1'b1;
      nxt_st.reload = nxt_st.reload_pre;
      if (st_ff.ctrl0[CTL_ONESHOT]) begin
        nxt_st.ctrl0[CTL_RUN] = 1'b0;
        nxt_st.cnt = CNT_ZERO;
      end
    end
    // Output prepare: PWM compare or fast forcing
    if (trig_rise && st_ff.ctrl0[CTL_ONESHOT] && st_ff.chan[CH0_FAST] && pwm_mode) begin
      nxt_st.oprep = (st_ff.chan[CH0_MODE_LO +: 3] == CMP_PWM1);
    end else if (st_ff.chan[CH0_MODE_LO +: 3] == CMP_PWM0) begin
      nxt_st.oprep = nxt_st.cnt < st_ff.cmp0;
    end else if (st_ff.chan[CH0_MODE_LO +: 3] == CMP_PWM1) begin
      nxt_st.oprep = nxt_st.cnt >= st_ff.cmp0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.reload <= RELOAD_RST;
      st_ff.reload_pre <= RELOAD_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Outputs
  always_comb begin
    hreadyout = 1'b1;
    hresp = 1'b0;
    hrdata = st_ff.rdata;
    trigger_output = st_ff.trg_out;
    output_prepare_level = st_ff.oprep;
    update_event = st_ff.upd_pulse;
    counter_value = st_ff.cnt;
  end

endmodule : tss_timer_slave
`default_nettype wire

/* File: dv/test_timer_slave_sync_one_shot.sv */
`timescale 1ns/1ns
`default_nettype none
module test_timer_slave_sync_one_shot
  import tss_pkg::*;
;
  // ==========================================================================
  // Signals
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout, hresp, trigger_output, output_prepare_level, update_event;
  logic [31:0] hrdata, q, r;
  logic [15:0] counter_value, c0;
  tss_trig_in_s trig_in;
  int n_errors = 0;
  int total_checks = 0;
  int n_upd = 0;
  int n_to = 0;
  int n_op = 0;
  int u, t;
  logic [7:0] offs [5] = '{OFS_CTRL0, OFS_SLAVE, OFS_IEN, OFS_FLAGS, 8'h40};
  tss_timer_slave uut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .trig_in(trig_in), .trigger_output(trigger_output),
    .output_prepare_level(output_prepare_level), .update_event(update_event),
    .counter_value(counter_value));
  tss_trig_model ptn (.clk_sys(clk_sys), .trig_in(trig_in));
  initial forever #50 clk_sys = ~clk_sys;
  // Tallied mid-cycle, so a read of a tally at a rising edge never races the tally itself
  always @(negedge clk_sys) begin
    if (update_event === 1'b1) n_upd++;
    if (trigger_output === 1'b1) n_to++;
    if (output_prepare_level === 1'b1) n_op++;
  end
  // ==========================================================================
  // Tasks
  function automatic logic [31:0] slv(input logic [2:0] ts, input logic [2:0] sm);
    return {24'h00_0000, 1'b1, ts, 1'b0, sm};
  endfunction : slv
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Whole words only; the master never counts on the slave answering at once
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    tick(20000);
    n_errors++;
    end_of_test();
  end
  // ==========================================================================
  // Sequence
  initial begin
    void'($urandom(32'h51546348));
    tick(8);
    rst <= 1'b0;
    foreach (offs[i]) begin
      bus(1'b0, offs[i], 0);
      chk(q, RESET_WORD);
    end
    repeat (4) begin
      r = $urandom;
      bus(1'b1, OFS_IEN, r);
      bus(1'b0, OFS_IEN, 0);
      chk(q, r & IEN_MASK);
      bus(1'b1, OFS_SLAVE, r & 32'h0000_00f0);
      bus(1'b0, OFS_SLAVE, 0);
      chk(q, r & 32'h0000_00f0);
    end
    bus(1'b1, OFS_SLAVE, 0);
    bus(1'b1, OFS_CTRL0, 1);
    // A read at an edge sees the value from before it, so let the run bit land first
    tick(1);
    c0 = counter_value;
    tick(10);
    chk(16'(counter_value - c0), 10);
    bus(1'b1, OFS_SLAVE, 32'(1 + $urandom % 3));
    c0 = counter_value;
    tick(10);
    chk(16'(counter_value - c0), 10);
    bus(1'b1, OFS_SLAVE, 0);
    bus(1'b1, OFS_CTRL0, 0);
    tick(1);
    c0 = counter_value;
    tick(5);
    chk(counter_value, c0);
    u = n_upd;
    bus(1'b1, OFS_EVGEN, 1);
    tick(2);
    chk(counter_value, 0);
    chk(n_upd - u, 1);
    bus(1'b0, OFS_FLAGS, 0);
    chk(q[FLG_UP], 1);
    // Restart on every internal trigger; source changes only with slave mode off
    bus(1'b1, OFS_CTRL0, 1);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, OFS_SLAVE, slv(3'(i), SM_OFF));
      bus(1'b1, OFS_SLAVE, slv(3'(i), SM_RESTART));
      tick(20);
      u = n_upd;
      t = n_to;
      ptn.pulse(i + 2, 6);
      tick(10);
      chk(n_upd - u, 1);
      chk(n_to - t, 1);
      chk(counter_value < 16'd32, 1);
    end
    bus(1'b0, OFS_FLAGS, 0);
    chk(q[FLG_TRG], 1);
    bus(1'b1, OFS_CTRL0, 3);
    tick(40);
    u = n_upd;
    ptn.pulse(5, 6);
    tick(10);
    chk(n_upd - u, 0);
    chk(counter_value < 16'd32, 1);
    bus(1'b1, OFS_CTRL0, 0);
    bus(1'b1, OFS_SLAVE, slv(3'd1, SM_OFF));
    bus(1'b1, OFS_SLAVE, slv(3'd1, SM_EXTCLK));
    bus(1'b1, OFS_CTRL0, 1);
    tick(2);
    c0 = counter_value;
    repeat (5) ptn.pulse(3, 4);
    chk(16'(counter_value - c0), 5);
    // Sync-start left off here: a polarity flip moves the trigger with no input edge
    bus(1'b1, OFS_SLAVE, slv(TS_FILT0, SM_OFF) & 32'h0000_007f);
    bus(1'b1, OFS_SLAVE, slv(TS_FILT0, SM_PAUSE) & 32'h0000_007f);
    for (int k = 0; k < 3; k++) begin
      if (k == 1) ptn.line(1, 1'b1);
      if (k == 2) ptn.line(1, 1'b0);
      if (k == 2) bus(1'b1, 8'h40, 1);
      tick(6);
      c0 = counter_value;
      tick(10);
      chk(16'(counter_value - c0), (k == 0) ? 0 : 10);
    end
    bus(1'b1, 8'h40, 0);
    bus(1'b1, OFS_CTRL0, 0);
    bus(1'b1, OFS_SLAVE, slv(3'd0, SM_OFF));
    bus(1'b1, OFS_SLAVE, slv(3'd0, SM_EVENT));
    bus(1'b1, OFS_RELOAD, 20);
    bus(1'b1, OFS_CTRL0, 8);
    bus(1'b1, OFS_EVGEN, 1);
    tick(2);
    u = n_upd;
    ptn.pulse(2, 4);
    tick(40);
    chk(n_upd - u, 1);
    chk(counter_value, 0);
    bus(1'b0, OFS_CTRL0, 0);
    chk(q, 8);
    // Compare output: PWM0 level at rest, then one-shot PWM1 pulses without and with fast forcing
    bus(1'b1, OFS_CHAN, 32'h0000_0060);
    bus(1'b1, OFS_CMP0, 5);
    tick(2);
    chk(output_prepare_level, 1);
    bus(1'b1, OFS_CMP0, 0);
    tick(2);
    chk(output_prepare_level, 0);
    for (int f = 0; f < 2; f++) begin
      bus(1'b1, OFS_CHAN, (f == 1) ? 32'h0000_0074 : 32'h0000_0070);
      bus(1'b1, OFS_CMP0, 10);
      tick(2);
      u = n_op;
      ptn.pulse(2, 4);
      tick(40);
      // High for counts 10 to 20 of the pulse, plus the forced cycle at the trigger when fast forcing is on
      chk(n_op - u, 11 + f);
    end
    bus(1'b1, OFS_FLAGS, 0);
    bus(1'b1, OFS_CTRL0, 4);
    u = n_upd;
    bus(1'b1, OFS_EVGEN, 1);
    bus(1'b0, OFS_FLAGS, 0);
    chk(q[FLG_UP], 0);
    chk(n_upd - u, 1);
    end_of_test();
  end
endmodule : test_timer_slave_sync_one_shot
`default_nettype wire

/* File: dv/tss_timer_slave_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================================
// Port checker
module tss_timer_slave_assertions
  import tss_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire tss_trig_in_s trig_in,
  input wire logic trigger_output,
  input wire logic update_event,
  input wire logic [15:0] counter_value
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Cycles since any trigger line moved; saturates so it never wraps
  tss_trig_in_s trig_ff;
  logic [7:0] quiet_ff;
  always_ff @(posedge clk_sys) begin
    trig_ff <= trig_in;
    if (rst || trig_in != trig_ff) begin
      quiet_ff <= 8'h00;
    end else if (quiet_ff != 8'hff) begin
      quiet_ff <= quiet_ff + 8'h01;
    end
  end
  AST_READY: assert property (hreadyout) else $error("wait state inserted");
  AST_OKAY: assert property (!hresp) else $error("error response");
  AST_RD_HOLD: assert property (!$past(hsel && hready && htrans == HTRANS_NONSEQ) |-> $stable(hrdata))
    else $error("read data moved without a transfer");
  AST_CNT_STEP: assert property ($changed(counter_value) |->
    counter_value == $past(counter_value) + 16'h0001 || counter_value == CNT_ZERO)
    else $error("counter jumped");
  AST_UPD_ONE: assert property (update_event |=> !update_event) else $error("update longer than a cycle");
  AST_UPD_ZERO: assert property (update_event |-> counter_value == CNT_ZERO) else $error("update left count");
  AST_UPD_AFTER: assert property (update_event |=> counter_value <= 16'h0001)
    else $error("count ran on past update");
  AST_TO_ONE: assert property (trigger_output |=> !trigger_output) else $error("trigger out too long");
  AST_TO_CAUSE: assert property (trigger_output |-> quiet_ff < 8'd16) else $error("trigger out uncaused");
  COV_UPD: cover property (update_event);
  COV_TO: cover property (trigger_output);
  COV_TOP: cover property (counter_value == 16'h0014);
endmodule : tss_timer_slave_assertions
bind tss_timer_slave tss_timer_slave_assertions u_chk (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
  .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .trig_in(trig_in), .trigger_output(trigger_output), .update_event(update_event),
  .counter_value(counter_value));
`default_nettype wire

/* File: dv/tss_trig_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================================
// Trigger sources: other timers and the two channel inputs
module tss_trig_model
  import tss_pkg::*;
(
  input wire logic clk_sys,
  output var tss_trig_in_s trig_in
);
  initial trig_in = '0;
  // Levels, not strobes: these sources are unsynchronised, so each level lasts several clocks
  task automatic line(input int b, input logic v);
    @(posedge clk_sys);
    trig_in[b] <= v;
  endtask : line
  task automatic pulse(input int b, input int n);
    line(b, 1'b1);
    repeat (n) @(posedge clk_sys);
    line(b, 1'b0);
    repeat (n) @(posedge clk_sys);
  endtask : pulse
endmodule : tss_trig_model
`default_nettype wire
